// ---- design/ldsc_pkg.sv ----
// Shared constants and types for the LED driver shutdown control ends
package ldsc_pkg;
  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_CTRL_OFS = 8'h00;
  localparam logic [7:0] DEV_SINK_LO_OFS = 8'h01;
  localparam logic [7:0] DEV_SINK_HI_OFS = 8'h02;
  localparam logic [7:0] DEV_DGHOST_OFS = 8'h60;
  localparam logic [7:0] DEV_RESET_OFS = 8'h7F;
  localparam logic [7:0] DEV_RESET_KEY = 8'hAE;
  localparam int SOFT_SHUTDOWN_BIT = 0;
  localparam int DG_ROW_LSB = 4;
  localparam int DG_SINK_LSB = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SINK_LO_RST = 8'h00;
  localparam logic [3:0] SINK_HI_RST = 4'h0;
  localparam logic [7:0] DGHOST_RST = 8'h00;
  localparam logic [7:0] DGHOST_OFF = 8'h00;
  // Typical de-ghost codes: row pull-down and sink pull-up
  localparam logic [7:0] DG_RECOMMENDED = 8'h55;
  localparam logic [1:0] ROW_LAST = 2'h2;
  localparam logic [1:0] ROW_RST = 2'h0;
  // ----------------------------------------------------------------
  // Host controller APB map
  // ----------------------------------------------------------------
  localparam logic [11:0] HOST_CMD_OFS = 12'h000;
  localparam logic [11:0] HOST_STAT_OFS = 12'h004;
  localparam logic [11:0] HOST_PIN_OFS = 12'h008;
  localparam logic [11:0] HOST_DGREC_OFS = 12'h00C;
  localparam int CMD_WDATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PIN_BIT = 1;
  localparam int STAT_REINIT_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam int STAT_RDATA_LSB = 8;
  localparam int PIN_RELEASE_BIT = 0;
  localparam int PIN_CLR_REINIT_BIT = 1;
  localparam int PIN_CLR_REFUSED_BIT = 2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PIN_SETTLE_NS = 100;
  localparam int PIN_SETTLE_CYC = (PIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LAST = 8'(PIN_SETTLE_CYC - 1);
  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SER_IDLE, SER_ACCESS, SER_RELEASE} ldsc_ser_e;
  typedef enum logic [1:0] {HST_IDLE, HST_XFER, HST_GUARD} ldsc_hst_e;
endpackage

// ---- design/ldsc_if.sv ----
// Link between host controller and LED driver device
`timescale 1ns/100ps
`default_nettype none
interface ldsc_if;
  logic hardware_shutdown_pin_n;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport device (input hardware_shutdown_pin_n, req, we, addr, wdata, output rdata, ack);
  modport host (output hardware_shutdown_pin_n, req, we, addr, wdata, input rdata, ack);
endinterface
`default_nettype wire

// ---- design/ldsc_device.sv ----
// LED driver device end: shutdown states, serial reset and register file
// Operation
// - Selectable row pull-down and sink pull-up levels
// - Host programs typical de-ghost levels; host only reports DG_RECOMMENDED at HOST_DGREC_OFS
// - Host disables de-ghost during hardware shutdown
// - Pin rising edge resets serial logic only
// - Host makes no transfer at pin rise
// - Registers unchanged in either shutdown
// - Soft shutdown bit zero turns sinks off
// - Register access allowed in soft shutdown
// - Pin low disables all analog circuitry
// - Pin high resumes normal operation
// - Register access allowed in hardware shutdown
// - Host rewrites registers after supply dip; host only flags reinit and holds the pin low until cleared
// - Reset key restores all register defaults
`timescale 1ns/100ps
`default_nettype none
module ldsc_device
  import ldsc_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  ldsc_if.device link, // Pin and serial port
  output logic [2:0] row_source_outputs, // Row source enables
  output logic [11:0] current_sink_outputs, // Current sink enables
  output logic [3:0] row_pulldown_level, // Row pull-down code
  output logic [3:0] sink_pullup_level, // Sink pull-up code
  output logic analog_enable // Analog circuitry on
);
  // ----------------------------------------------------------------
  // Pin synchroniser and edge
  // ----------------------------------------------------------------
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  wire pin_rise = pin_sync_q & ~pin_prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= link.hardware_shutdown_pin_n;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Serial access engine
  // ----------------------------------------------------------------
  ldsc_ser_e ser_q;
  ldsc_ser_e ser_d;
  logic [7:0] rdata_q;
  logic [7:0] ctrl_q;
  logic [7:0] sink_lo_q;
  logic [3:0] sink_hi_q;
  logic [7:0] dghost_q;
  logic [1:0] row_q;

  // Access works in any power state, no gating by shutdown
  wire access = (ser_q == SER_ACCESS);
  // Transfer cut by a pin rise leaves registers alone
  wire wr = access & ~pin_rise & link.we;
  wire wr_ctrl = wr & (link.addr == DEV_CTRL_OFS);
  wire wr_sink_lo = wr & (link.addr == DEV_SINK_LO_OFS);
  wire wr_sink_hi = wr & (link.addr == DEV_SINK_HI_OFS);
  wire wr_dghost = wr & (link.addr == DEV_DGHOST_OFS);
  wire wr_reset = wr & (link.addr == DEV_RESET_OFS) & (link.wdata == DEV_RESET_KEY);
  wire [7:0] rd_mux = (link.addr == DEV_CTRL_OFS) ? ctrl_q :
                      (link.addr == DEV_SINK_LO_OFS) ? sink_lo_q :
                      (link.addr == DEV_SINK_HI_OFS) ? {4'h0, sink_hi_q} :
                      (link.addr == DEV_DGHOST_OFS) ? dghost_q : 8'h00;

  always_comb
  begin
    ser_d = ser_q;
    unique case (ser_q)
      SER_IDLE: if (link.req) ser_d = SER_ACCESS;
      SER_ACCESS: ser_d = SER_RELEASE;
      SER_RELEASE: if (!link.req) ser_d = SER_IDLE;
    endcase
    if (pin_rise)
      ser_d = SER_IDLE;
  end

  assign link.ack = access & ~pin_rise;
  assign link.rdata = rdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ser_q <= SER_IDLE;
    else
      ser_q <= ser_d;
  end

  // Read data captured as the request is taken
  wire take = (ser_q == SER_IDLE) & link.req;
  wire [7:0] rdata_d = take ? rd_mux : rdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // ----------------------------------------------------------------
  // Register file, untouched by shutdown or pin edges
  // ----------------------------------------------------------------
  // Only writes change contents, never a power state
  wire [7:0] ctrl_d = wr_reset ? CTRL_RST : wr_ctrl ? link.wdata : ctrl_q;
  wire [7:0] sink_lo_d = wr_reset ? SINK_LO_RST : wr_sink_lo ? link.wdata : sink_lo_q;
  wire [3:0] sink_hi_d = wr_reset ? SINK_HI_RST : wr_sink_hi ? link.wdata[3:0] : sink_hi_q;
  wire [7:0] dghost_d = wr_reset ? DGHOST_RST : wr_dghost ? link.wdata : dghost_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= CTRL_RST;
    else
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sink_lo_q <= SINK_LO_RST;
    else
      sink_lo_q <= sink_lo_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sink_hi_q <= SINK_HI_RST;
    else
      sink_hi_q <= sink_hi_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dghost_q <= DGHOST_RST;
    else
      dghost_q <= dghost_d;
  end

  // ----------------------------------------------------------------
  // Power states and outputs
  // ----------------------------------------------------------------
  wire soft_on = ctrl_q[SOFT_SHUTDOWN_BIT];
  wire analog_on = pin_sync_q;
  wire running = soft_on & analog_on;

  // Row scan advances only while running
  wire [1:0] row_d = (!running || row_q == ROW_LAST) ? ROW_RST : row_q + 2'h1;
  wire [2:0] rows_d = running ? (3'h1 << row_q) : 3'h0;
  wire [11:0] sinks_d = running ? {sink_hi_q, sink_lo_q} : 12'h000;
  wire [3:0] pulldown_d = analog_on ? dghost_q[DG_ROW_LSB +: 4] : 4'h0;
  wire [3:0] pullup_d = analog_on ? dghost_q[DG_SINK_LSB +: 4] : 4'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_q <= ROW_RST;
      row_source_outputs <= 3'h0;
    end
    else
    begin
      row_q <= row_d;
      row_source_outputs <= rows_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      current_sink_outputs <= 12'h000;
    else
      current_sink_outputs <= sinks_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_pulldown_level <= 4'h0;
      sink_pullup_level <= 4'h0;
    end
    else
    begin
      row_pulldown_level <= pulldown_d;
      sink_pullup_level <= pullup_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_enable <= 1'b0;
    else
      analog_enable <= analog_on;
  end
endmodule
`default_nettype wire

// ---- design/ldsc_host.sv ----
// Host controller end: APB command port, pin control and serial master
`timescale 1ns/100ps
`default_nettype none
module ldsc_host
  import ldsc_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic supply_dip, // Supply fell into dip band
  ldsc_if.host link // Pin and serial port
);
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_acc = psel & penable;
  wire hit_cmd = (paddr == HOST_CMD_OFS);
  wire hit_stat = (paddr == HOST_STAT_OFS);
  wire hit_pin = (paddr == HOST_PIN_OFS);
  wire hit_dgrec = (paddr == HOST_DGREC_OFS);
  wire mapped = hit_cmd | hit_stat | hit_pin | hit_dgrec;
  wire wr_cmd = apb_acc & pwrite & hit_cmd;
  wire wr_pin = apb_acc & pwrite & hit_pin;

  ldsc_hst_e st_q;
  logic pin_q;
  logic want_q;
  logic reinit_q;
  logic refused_q;
  logic pend_q;
  logic lower_q;
  logic req_q;
  logic we_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] cnt_q;
  logic dip_meta_q;
  logic dip_sync_q;

  // Pending lowering counts as busy, its transfer owns the link registers
  wire busy = pend_q | (st_q != HST_IDLE) | (~want_q & pin_q);
  wire [7:0] cmd_addr = pwdata[CMD_ADDR_LSB +: 8];
  wire [7:0] cmd_wdata = pwdata[CMD_WDATA_LSB +: 8];
  // Nonzero de-ghost write refused while the pin holds shutdown
  wire dg_block = pwdata[CMD_WRITE_BIT] & (cmd_addr == DEV_DGHOST_OFS) & ~pin_q
                  & (cmd_wdata != DGHOST_OFF);
  wire cmd_ok = wr_cmd & ~busy & ~dg_block;
  wire cmd_bad = wr_cmd & (busy | dg_block);
  wire [31:0] stat_word = {16'h0000, rdata_q, 4'h0, refused_q, reinit_q, pin_q, busy};

  assign pready = 1'b1;
  assign pslverr = apb_acc & ~mapped;
  assign prdata = hit_stat ? stat_word :
                  hit_pin ? {31'h0, want_q} :
                  hit_dgrec ? {24'h0, DG_RECOMMENDED} : 32'h0;

  assign link.hardware_shutdown_pin_n = pin_q;
  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;

  // ----------------------------------------------------------------
  // Supply dip synchroniser and status flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dip_meta_q <= 1'b0;
      dip_sync_q <= 1'b0;
      reinit_q <= 1'b0;
      refused_q <= 1'b0;
      want_q <= 1'b0;
    end
    else
    begin
      dip_meta_q <= supply_dip;
      dip_sync_q <= dip_meta_q;
      // Set wins over clear
      if (dip_sync_q & ~pin_q)
        reinit_q <= 1'b1;
      else if (wr_pin & pwdata[PIN_CLR_REINIT_BIT])
        reinit_q <= 1'b0;
      if (cmd_bad)
        refused_q <= 1'b1;
      else if (wr_pin & pwdata[PIN_CLR_REFUSED_BIT])
        refused_q <= 1'b0;
      if (wr_pin)
        want_q <= pwdata[PIN_RELEASE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pin sequencing and serial master
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= HST_IDLE;
      pin_q <= 1'b0;
      pend_q <= 1'b0;
      lower_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      cnt_q <= 8'h00;
    end
    else
    begin
      if (cmd_ok)
      begin
        pend_q <= 1'b1;
        we_q <= pwdata[CMD_WRITE_BIT];
        addr_q <= cmd_addr;
        wdata_q <= cmd_wdata;
      end
      unique case (st_q)
        HST_IDLE:
        begin
          if (want_q && !pin_q && !reinit_q)
          begin
            pin_q <= 1'b1;
            cnt_q <= 8'h00;
            st_q <= HST_GUARD;
          end
          else if (!want_q && pin_q)
          begin
            // De-ghost off before entering shutdown
            lower_q <= 1'b1;
            req_q <= 1'b1;
            we_q <= 1'b1;
            addr_q <= DEV_DGHOST_OFS;
            wdata_q <= DGHOST_OFF;
            st_q <= HST_XFER;
          end
          else if (pend_q)
          begin
            pend_q <= 1'b0;
            req_q <= 1'b1;
            st_q <= HST_XFER;
          end
        end
        HST_XFER:
        begin
          if (link.ack)
          begin
            req_q <= 1'b0;
            rdata_q <= link.rdata;
            if (lower_q)
              pin_q <= 1'b0;
            lower_q <= 1'b0;
            st_q <= HST_IDLE;
          end
        end
        HST_GUARD:
        begin
          // No transfer until the device has seen the pin rise
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == SETTLE_LAST)
            st_q <= HST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/ldsc_chk.sv ----
// Assertions on the link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module ldsc_chk
  import ldsc_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic hardware_shutdown_pin_n, // Shutdown pin
  input wire logic req, // Request
  input wire logic we, // Write
  input wire logic [7:0] addr, // Address
  input wire logic [7:0] wdata, // Write data
  input wire logic [7:0] rdata, // Read data
  input wire logic ack // Answer
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Shadow of one device register
  // ----------------------------------------
  logic [7:0] sink_q;
  wire wr_ack = ack && we;
  wire key_hit = wr_ack && addr == DEV_RESET_OFS && wdata == DEV_RESET_KEY;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sink_q <= SINK_LO_RST;
    else if (wr_ack && addr == DEV_SINK_LO_OFS)
      sink_q <= wdata;
    else if (key_hit)
      sink_q <= SINK_LO_RST;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_gap;
    !req [*2];
  endsequence
  sequence s_quiet;
    !req [*8];
  endsequence
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_soft: assert property ($rose(req) && hardware_shutdown_pin_n |=> ack)
    else $error("no answer with pin high");
  chk_ack_hard: assert property ($rose(req) && !hardware_shutdown_pin_n |=> ack)
    else $error("no answer in hardware shutdown");
  chk_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
    && $stable(wdata))
    else $error("request changed before answer");
  chk_req_gap: assert property (ack |=> s_gap)
    else $error("request spacing too short");
  chk_rise_quiet: assert property ($rose(hardware_shutdown_pin_n) |-> s_quiet)
    else $error("transfer near pin rise");
  chk_dg_off: assert property ($fell(hardware_shutdown_pin_n) |->
    $past(wr_ack && addr == DEV_DGHOST_OFS && wdata == DGHOST_OFF))
    else $error("pin lowered without de-ghost off");
  chk_dg_refuse: assert property (req && we && addr == DEV_DGHOST_OFS
    && !hardware_shutdown_pin_n |-> wdata == DGHOST_OFF)
    else $error("de-ghost enabled in shutdown");
  chk_sink_keep: assert property (ack && !we && addr == DEV_SINK_LO_OFS |-> rdata == sink_q)
    else $error("sink register lost its value");
endmodule
`default_nettype wire

// ---- tb/led_driver_shutdown_control_tb_top.sv ----
// Bench driving the host over APB with the device on its link
`timescale 1ns/100ps
`default_nettype none
module led_driver_shutdown_control_tb_top
  import ldsc_pkg::*;
;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic supply_dip = 1'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] rows;
  logic [11:0] sinks;
  logic [3:0] rpd;
  logic [3:0] spu;
  logic aen;
  logic [31:0] rd;
  logic [7:0] db;
  logic err;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  ldsc_if lnk();
  ldsc_host i_ldsc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_dip(supply_dip), .link(lnk));
  ldsc_device i_ldsc_device (.pclk(pclk), .presetn(presetn), .link(lnk),
    .row_source_outputs(rows), .current_sink_outputs(sinks), .row_pulldown_level(rpd),
    .sink_pullup_level(spu), .analog_enable(aen));
  ldsc_chk i_ldsc_chk (.pclk(pclk), .presetn(presetn),
    .hardware_shutdown_pin_n(lnk.hardware_shutdown_pin_n), .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
  // ----------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic idle();
    do
      apb(1'h0, HOST_STAT_OFS, 32'h0);
    while (rd[STAT_BUSY_BIT] !== 1'h0);
    db = rd[STAT_RDATA_LSB +: 8];
  endtask
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, HOST_CMD_OFS, {15'h0, w, a, d});
    idle();
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, HOST_PIN_OFS, 32'h0);
    cmp("pin_reg", 32'h0, rd);
    cmp("analog", 32'h0, aen);
    apb(1'h0, HOST_DGREC_OFS, 32'h0);
    cmp("dgrec", {24'h0, DG_RECOMMENDED}, rd);
    apb(1'h0, 12'h010, 32'h0);
    cmp("unmapped", 32'h1, {rd[30:0], err});
    $display("test reset done");
    dev(1'h1, DEV_SINK_LO_OFS, 8'hA5);
    dev(1'h0, DEV_SINK_LO_OFS, 8'h00);
    cmp("sink_lo", 32'hA5, db);
    dev(1'h1, DEV_DGHOST_OFS, DG_RECOMMENDED);
    cmp("refused", 32'h1, rd[STAT_REFUSED_BIT]);
    apb(1'h1, HOST_PIN_OFS, 32'h4);
    dev(1'h0, DEV_DGHOST_OFS, 8'h00);
    cmp("dg_hw", 32'h0, {db, rd[STAT_REFUSED_BIT]});
    cmp("sinks_hw", 32'h0, sinks);
    $display("test hardware shutdown done");
    apb(1'h1, HOST_PIN_OFS, 32'h1);
    idle();
    cmp("analog_on", 32'h1, aen);
    cmp("pin_up", 32'h1, rd[STAT_PIN_BIT]);
    dev(1'h0, DEV_SINK_LO_OFS, 8'h00);
    cmp("sink_kept", 32'hA5, db);
    dev(1'h1, DEV_DGHOST_OFS, DG_RECOMMENDED);
    cmp("levels", 32'h55, {rpd, spu});
    cmp("sinks_soft", 32'h0, sinks);
    dev(1'h1, DEV_SINK_HI_OFS, 8'h03);
    dev(1'h1, DEV_CTRL_OFS, 8'h01);
    repeat (4) @(posedge pclk);
    cmp("sinks_on", 32'h3A5, sinks);
    cmp("rows_on", 32'h1, $onehot(rows));
    dev(1'h1, DEV_CTRL_OFS, 8'h00);
    repeat (4) @(posedge pclk);
    cmp("sinks_off", 32'h0, sinks);
    dev(1'h0, DEV_SINK_HI_OFS, 8'h00);
    cmp("sink_hi", 32'h3, db);
    $display("test run and soft shutdown done");
    dev(1'h1, DEV_CTRL_OFS, 8'h01);
    apb(1'h1, HOST_PIN_OFS, 32'h0);
    idle();
    repeat (6) @(posedge pclk);
    cmp("analog_off", 32'h0, {aen, rpd, spu, sinks});
    dev(1'h0, DEV_DGHOST_OFS, 8'h00);
    cmp("dg_auto_off", 32'h0, db);
    dev(1'h0, DEV_CTRL_OFS, 8'h00);
    cmp("ctrl_kept", 32'h1, db);
    $display("test lower pin done");
    supply_dip <= 1'h1;
    repeat (4) @(posedge pclk);
    supply_dip <= 1'h0;
    apb(1'h1, HOST_PIN_OFS, 32'h1);
    repeat (15) @(posedge pclk);
    apb(1'h0, HOST_STAT_OFS, 32'h0);
    cmp("reinit", 32'h4, rd[2:0] & 32'h6);
    apb(1'h1, HOST_PIN_OFS, 32'h2);
    apb(1'h1, HOST_PIN_OFS, 32'h1);
    idle();
    cmp("pin_again", 32'h2, rd[2:0]);
    $display("test supply dip done");
    dev(1'h1, DEV_RESET_OFS, DEV_RESET_KEY);
    dev(1'h0, DEV_SINK_LO_OFS, 8'h00);
    cmp("sink_dflt", {24'h0, SINK_LO_RST}, db);
    dev(1'h0, DEV_CTRL_OFS, 8'h00);
    cmp("ctrl_dflt", {24'h0, CTRL_RST}, db);
    cmp("sinks_dflt", 32'h0, sinks);
    $display("test reset key done");
    give_verdict();
  end
endmodule
`default_nettype wire
